// file: hw/aiop_defines.svh
// register offsets, field positions, reset values for the io ports
// assumes a 32-bit avalon-mm slave, one register per aligned word
`ifndef AIOP_DEFINES_SVH
`define AIOP_DEFINES_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define AIOP_IDX_ANALOG_DATA     6'h18
`define AIOP_IDX_ANALOG_DIR      6'h1a
`define AIOP_IDX_ANALOG_IE       6'h1b
`define AIOP_IDX_TIMER_DATA      6'h1c
`define AIOP_IDX_TIMER_DIR       6'h1e
`define AIOP_IDX_TIMER_FSEL      6'h1f
`define AIOP_IDX_IRQ_STATUS      6'h20
`define AIOP_IDX_IRQ_MASK        6'h21
`define AIOP_IDX_EXTERNAL_INTERRUPT_ZERO_MODE       6'h22

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define AIOP_RST_ANALOG_LATCH    8'hff
`define AIOP_RST_ANALOG_DIR      8'h00
`define AIOP_RST_ANALOG_IE       8'h00
`define AIOP_RST_TIMER_LATCH     6'h3f
`define AIOP_RST_TIMER_DIR       6'h00
`define AIOP_RST_TIMER_FSEL      6'h00
`define AIOP_RST_EXTERNAL_INTERRUPT_ZERO_MODE       2'h0

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define AIOP_FSEL_IMPL_MASK      6'h36
`define AIOP_BIT_TMR_A_OUT       1
`define AIOP_BIT_TMR_B_OUT       2
`define AIOP_BIT_TMR_C_OUT       4
`define AIOP_BIT_TMR_A_CLK       0
`define AIOP_BIT_TMR_C_CLK       3
`define AIOP_BIT_EXTERNAL_INTERRUPT_ZERO            5
`define AIOP_BIT_MODE_EDGE       0
`define AIOP_BIT_MODE_LEVEL      1
`define AIOP_BIT_STAT_EXTERNAL_INTERRUPT_ZERO       0

`endif

// file: hw/aiop_external_interrupt_zero_detect.sv
// external interrupt zero detector: edge or level on a synced pin
// assumes the pin level has already passed two flip-flops
`timescale 1ns/10ps

module aiop_external_interrupt_zero_detect (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  // control
  input  wire logic                  enable,
  input  wire aiop_pkg::aiop_det_type mode,
  // pin
  input  wire logic                  pin_level,
  // result
  output logic                       req_ff
);
  import aiop_pkg::*;

  logic prev_ff;
  logic nxt_req;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= pin_level;
    end
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  always_comb begin
    nxt_req = 1'b0;
    if (enable) begin
      case (mode)
        AIOP_DET_RISE: nxt_req = pin_level & ~prev_ff;
        AIOP_DET_FALL: nxt_req = ~pin_level & prev_ff;
        AIOP_DET_HIGH: nxt_req = pin_level;
        AIOP_DET_LOW:  nxt_req = ~pin_level;
        default:       nxt_req = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      req_ff <= 1'b0;
    end else begin
      req_ff <= nxt_req;
    end
  end

endmodule // aiop_external_interrupt_zero_detect

// file: hw/aiop_pkg.sv
// types shared by the io port block and its interrupt detector
// assumes nothing beyond the defines header
package aiop_pkg;

  // ---------------------------------------------------------------
  // pin carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe;
  } aiop_apin_type;

  typedef struct packed {
    logic [5:0] level;
    logic [5:0] oe;
  } aiop_tpin_type;

  // ---------------------------------------------------------------
  // timer links
  // ---------------------------------------------------------------
  typedef struct packed {
    logic a_out;
    logic b_out;
    logic c_out;
  } aiop_tmr_out_type;

  typedef struct packed {
    logic a_clk;
    logic c_clk;
  } aiop_tmr_in_type;

  // ---------------------------------------------------------------
  // external_interrupt_zero detection: {level select, edge select}
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    AIOP_DET_RISE = 2'h0,
    AIOP_DET_FALL = 2'h1,
    AIOP_DET_HIGH = 2'h2,
    AIOP_DET_LOW  = 2'h3
  } aiop_det_type;

endpackage

// file: hw/aiop_top.sv
// analog-capable 8-bit port and 6-bit timer port with avalon-mm slave
// assumes one clock core_clk, async active-low rstn, pins async
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps
`include "aiop_defines.svh"

module aiop_top (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  // avalon-mm slave
  input  wire logic [7:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic [31:0]                    avs_readdata,
  output logic                           avs_waitrequest,
  // analog-capable port pins
  input  wire logic [7:0]                analog_pin_in,
  output aiop_pkg::aiop_apin_type        analog_pin,
  output logic [7:0]                     converter_upper_inputs,
  // timer port pins
  input  wire logic [5:0]                timer_pin_in,
  output aiop_pkg::aiop_tpin_type        timer_pin,
  // timer links
  input  wire aiop_pkg::aiop_tmr_out_type timer_out,
  output aiop_pkg::aiop_tmr_in_type      timer_in,
  // interrupts
  output logic                           external_interrupt_zero,
  output logic                           irq
);
  import aiop_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]   analog_latch_ff;
  logic [7:0]   analog_port_direction_ff;
  logic [7:0]   analog_port_input_enable_ff;
  logic [5:0]   timer_latch_ff;
  logic [5:0]   timer_port_direction_ff;
  logic [5:0]   timer_port_function_select_ff;
  logic [1:0]   external_interrupt_zero_mode_ff;
  logic [0:0]   irq_status_ff;
  logic [0:0]   irq_mask_ff;
  logic [31:0]  rdata_ff;
  logic         wait_ff;
  logic         irq_ff;
  logic         ext_external_interrupt_zero_ff;
  logic [7:0]   conv_en_ff;
  aiop_apin_type apin_ff;
  aiop_tpin_type tpin_ff;
  aiop_tmr_in_type tin_ff;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [7:0]   asy1_ff;
  logic [7:0]   asy2_ff;
  logic [5:0]   tsy1_ff;
  logic [5:0]   tsy2_ff;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      asy1_ff <= 8'h00;
      asy2_ff <= 8'h00;
      tsy1_ff <= 6'h00;
      tsy2_ff <= 6'h00;
    end else begin
      asy1_ff <= analog_pin_in;
      asy2_ff <= asy1_ff;
      tsy1_ff <= timer_pin_in;
      tsy2_ff <= tsy1_ff;
    end
  end

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic [5:0]   idx;
  logic         acc_go;
  logic         wr_go;
  logic [7:0]   wbyte;
  logic [31:0]  nxt_rdata;
  logic [7:0]   analog_rd;
  logic [5:0]   timer_rd;

  assign idx    = avs_address[7:2];
  // a request completes at the edge where wait is low
  assign acc_go = (avs_read | avs_write) & ~wait_ff;
  assign wr_go  = acc_go & avs_write & avs_byteenable[0];
  assign wbyte  = avs_writedata[7:0];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wait_ff <= 1'b1;
    end else if (acc_go) begin
      wait_ff <= 1'b1;
    end else if (avs_read | avs_write) begin
      wait_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // digital input path is cut while input is disabled and the pin is not driven
  assign analog_rd = asy2_ff
                   & (analog_port_direction_ff
                   | analog_port_input_enable_ff);
  assign timer_rd  = tsy2_ff;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (idx)
      `AIOP_IDX_ANALOG_DATA: nxt_rdata[7:0] = analog_rd;
      `AIOP_IDX_TIMER_DATA:  nxt_rdata[5:0] = timer_rd;
      `AIOP_IDX_IRQ_STATUS:  nxt_rdata[0]   = irq_status_ff[0];
      `AIOP_IDX_IRQ_MASK:    nxt_rdata[0]   = irq_mask_ff[0];
      `AIOP_IDX_EXTERNAL_INTERRUPT_ZERO_MODE:   nxt_rdata[1:0] = external_interrupt_zero_mode_ff;
      default:               nxt_rdata      = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read & wait_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // analog-capable port registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      analog_latch_ff <= `AIOP_RST_ANALOG_LATCH;
    end else if (wr_go && idx == `AIOP_IDX_ANALOG_DATA) begin
      analog_latch_ff <= wbyte;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      analog_port_direction_ff <= `AIOP_RST_ANALOG_DIR;
    end else if (wr_go && idx == `AIOP_IDX_ANALOG_DIR) begin
      analog_port_direction_ff <= wbyte;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      analog_port_input_enable_ff <= `AIOP_RST_ANALOG_IE;
    end else if (wr_go && idx == `AIOP_IDX_ANALOG_IE) begin
      analog_port_input_enable_ff <= wbyte;
    end
  end

  // ---------------------------------------------------------------
  // timer port registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      timer_latch_ff <= `AIOP_RST_TIMER_LATCH;
    end else if (wr_go && idx == `AIOP_IDX_TIMER_DATA) begin
      timer_latch_ff <= wbyte[5:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      timer_port_direction_ff <= `AIOP_RST_TIMER_DIR;
    end else if (wr_go && idx == `AIOP_IDX_TIMER_DIR) begin
      timer_port_direction_ff <= wbyte[5:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      timer_port_function_select_ff <= `AIOP_RST_TIMER_FSEL;
    end else if (wr_go && idx == `AIOP_IDX_TIMER_FSEL) begin
      // bits 0 and 3 have no function select
      timer_port_function_select_ff <=
        wbyte[5:0] & `AIOP_FSEL_IMPL_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      external_interrupt_zero_mode_ff <= `AIOP_RST_EXTERNAL_INTERRUPT_ZERO_MODE;
    end else if (wr_go && idx == `AIOP_IDX_EXTERNAL_INTERRUPT_ZERO_MODE) begin
      external_interrupt_zero_mode_ff <= wbyte[1:0];
    end
  end

  // ---------------------------------------------------------------
  // analog-capable pin drive
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      apin_ff.level <= `AIOP_RST_ANALOG_LATCH;
      apin_ff.oe    <= 8'h00;
    end else begin
      apin_ff.level <= analog_latch_ff;
      apin_ff.oe    <= analog_port_direction_ff;
    end
  end

  // pins not driven are offered to the converter
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      conv_en_ff <= 8'hff;
    end else begin
      conv_en_ff <= ~analog_port_direction_ff;
    end
  end

  // ---------------------------------------------------------------
  // timer pin drive, one mux per bit
  // ---------------------------------------------------------------
  logic [5:0] alt_src;
  logic [5:0] alt_on;

  assign alt_src = {1'b0, timer_out.c_out, 1'b0,
                    timer_out.b_out, timer_out.a_out, 1'b0};
  assign alt_on  = timer_port_function_select_ff
                 & timer_port_direction_ff;

  logic [5:0] nxt_tlevel;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_tpin
      assign nxt_tlevel[gi] = alt_on[gi] ? alt_src[gi]
                                         : timer_latch_ff[gi];
    end
  endgenerate

  // one process owns the whole pin register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tpin_ff.level <= `AIOP_RST_TIMER_LATCH;
      tpin_ff.oe    <= `AIOP_RST_TIMER_DIR;
    end else begin
      tpin_ff.level <= nxt_tlevel;
      tpin_ff.oe    <= timer_port_direction_ff;
    end
  end

  // ---------------------------------------------------------------
  // timer clock inputs
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tin_ff <= '0;
    end else begin
      tin_ff.a_clk <= tsy2_ff[`AIOP_BIT_TMR_A_CLK];
      tin_ff.c_clk <= tsy2_ff[`AIOP_BIT_TMR_C_CLK];
    end
  end

  // ---------------------------------------------------------------
  // external interrupt zero
  // ---------------------------------------------------------------
  logic         external_interrupt_zero_en;
  logic         external_interrupt_zero_req;
  aiop_det_type external_interrupt_zero_mode;

  assign external_interrupt_zero_en   = timer_port_function_select_ff[`AIOP_BIT_EXTERNAL_INTERRUPT_ZERO]
                   & ~timer_port_direction_ff[`AIOP_BIT_EXTERNAL_INTERRUPT_ZERO];
  assign external_interrupt_zero_mode = aiop_det_type'(external_interrupt_zero_mode_ff);

  aiop_external_interrupt_zero_detect u_external_interrupt_zero (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .enable    (external_interrupt_zero_en),
    .mode      (external_interrupt_zero_mode),
    .pin_level (tsy2_ff[`AIOP_BIT_EXTERNAL_INTERRUPT_ZERO]),
    .req_ff    (external_interrupt_zero_req)
  );

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ext_external_interrupt_zero_ff <= 1'b0;
    end else begin
      ext_external_interrupt_zero_ff <= external_interrupt_zero_req;
    end
  end

  // ---------------------------------------------------------------
  // sticky status, mask, interrupt line
  // ---------------------------------------------------------------
  logic [0:0] nxt_status;
  logic [0:0] st_clr;

  assign st_clr = (wr_go && idx == `AIOP_IDX_IRQ_STATUS)
                ? wbyte[0:0] : 1'b0;
  // a new event wins over a clear in the same cycle
  assign nxt_status = (irq_status_ff & ~st_clr) | external_interrupt_zero_req;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_status_ff <= 1'b0;
    end else begin
      irq_status_ff <= nxt_status;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask_ff <= 1'b0;
    end else if (wr_go && idx == `AIOP_IDX_IRQ_MASK) begin
      irq_mask_ff <= wbyte[0:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_status & irq_mask_ff);
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign avs_readdata            = rdata_ff;
  assign avs_waitrequest         = wait_ff;
  assign analog_pin              = apin_ff;
  assign converter_upper_inputs  = conv_en_ff;
  assign timer_pin               = tpin_ff;
  assign timer_in                = tin_ff;
  assign external_interrupt_zero = ext_external_interrupt_zero_ff;
  assign irq                     = irq_ff;

endmodule // aiop_top

// file: verif/aiop_pin_model.sv
// outside world of the io port block: pin wires and timer outputs
// assumes the bench sets what outside parts put on undriven pins
`timescale 1ns/10ps

module aiop_pin_model (
  // pins from the block
  input  wire aiop_pkg::aiop_apin_type analog_pin,
  input  wire aiop_pkg::aiop_tpin_type timer_pin,
  // outside sources
  input  wire logic [7:0]              analog_ext,
  input  wire logic [5:0]              timer_ext,
  input  wire logic [2:0]              tmr_drive,
  // levels seen by the block
  output logic [7:0]                   analog_pin_in,
  output logic [5:0]                   timer_pin_in,
  output aiop_pkg::aiop_tmr_out_type   timer_out
);
  import aiop_pkg::*;
  // driven bits carry the block's level, free bits the outside source
  assign analog_pin_in = (analog_pin.oe & analog_pin.level)
                       | (~analog_pin.oe & analog_ext);
  assign timer_pin_in  = (timer_pin.oe & timer_pin.level)
                       | (~timer_pin.oe & timer_ext);
  assign timer_out     = aiop_tmr_out_type'(tmr_drive);
endmodule // aiop_pin_model

// file: verif/aiop_top_asserts.sv
// concurrent checks on the io port block, bound to its top ports
// assumes one clock core_clk and asynchronous active-low rstn
`timescale 1ns/10ps

module aiop_top_asserts (
  // clock and reset
  input wire logic                      core_clk,
  input wire logic                      rstn,
  // bus
  input wire logic                      avs_read,
  input wire logic                      avs_write,
  input wire logic                      avs_waitrequest,
  // pins and links
  input wire aiop_pkg::aiop_apin_type   analog_pin,
  input wire logic [7:0]                converter_upper_inputs,
  input wire logic [5:0]                timer_pin_in,
  input wire aiop_pkg::aiop_tpin_type   timer_pin,
  input wire aiop_pkg::aiop_tmr_in_type timer_in,
  input wire logic                      external_interrupt_zero,
  input wire logic                      irq
);
  import aiop_pkg::*;
  logic [1:0] rst_age_ff;

  // ----------------------------------------------------------
  // edges since reset, guards the synchroniser history
  // ----------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_age_ff <= 2'h0;
    end else if (rst_age_ff != 2'h3) begin
      rst_age_ff <= rst_age_ff + 2'h1;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_req_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  property p_rst_analog;
    $rose(rstn) |-> analog_pin == {8'hff, 8'h00}
      && converter_upper_inputs == 8'hff;
  endproperty
  property p_rst_timer;
    $rose(rstn) |-> timer_pin == {6'h3f, 6'h00} && timer_in == 2'h0 && !irq;
  endproperty
  property p_conv_dir;
    converter_upper_inputs == ~analog_pin.oe;
  endproperty
  property p_req_answer;
    s_req_taken |=> s_answer;
  endproperty
  property p_aoe_cause;
    $changed(analog_pin.oe) |-> $past(avs_write) || $past(avs_write, 2);
  endproperty
  property p_toe_cause;
    $changed(timer_pin.oe) |-> $past(avs_write) || $past(avs_write, 2);
  endproperty
  property p_clk_a;
    rst_age_ff == 2'h3 |-> timer_in.a_clk == $past(timer_pin_in[0], 3);
  endproperty
  property p_clk_c;
    rst_age_ff == 2'h3 |-> timer_in.c_clk == $past(timer_pin_in[3], 3);
  endproperty
  property p_irq_cause;
    $rose(irq) |-> external_interrupt_zero || $past(external_interrupt_zero)
      || $past(external_interrupt_zero, 2) || $past(avs_write)
      || $past(avs_write, 2);
  endproperty

  a_rst_analog: assert property (p_rst_analog)
    else $error("analog port not at reset state");
  a_rst_timer: assert property (p_rst_timer)
    else $error("timer port not at reset state");
  a_conv_dir: assert property (p_conv_dir)
    else $error("converter offer disagrees with direction");
  a_req_answer: assert property (p_req_answer)
    else $error("bus answer missing or too long");
  a_aoe_cause: assert property (p_aoe_cause)
    else $error("analog drive changed without a write");
  a_toe_cause: assert property (p_toe_cause)
    else $error("timer drive changed without a write");
  a_clk_a: assert property (p_clk_a)
    else $error("timer a clock not following pin 0");
  a_clk_c: assert property (p_clk_c)
    else $error("timer c clock not following pin 3");
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq rose with no event or write");
endmodule // aiop_top_asserts

bind aiop_top aiop_top_asserts u_chk (
  .core_clk(core_clk), .rstn(rstn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .analog_pin(analog_pin), .converter_upper_inputs(converter_upper_inputs),
  .timer_pin_in(timer_pin_in), .timer_pin(timer_pin), .timer_in(timer_in),
  .external_interrupt_zero(external_interrupt_zero), .irq(irq)
);

// file: verif/tb_top.sv
// self-checking bench for the io port block and its pin model
// assumes avalon-mm slave that answers by dropping waitrequest
`timescale 1ns/10ps
`include "aiop_defines.svh"
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
    end \
  end

module tb_top;
  import aiop_pkg::*;
  typedef struct {logic [7:0] dir, ie, latch, ext, rd;} aiop_row_type;
  logic             core_clk, rstn, avs_read, avs_write, avs_waitrequest;
  logic [7:0]       avs_address, analog_pin_in, converter_upper_inputs;
  logic [31:0]      avs_writedata, avs_readdata, rd;
  logic [3:0]       avs_byteenable;
  logic [5:0]       timer_pin_in, timer_ext;
  logic [7:0]       analog_ext;
  logic [2:0]       tmr_drive;
  logic             external_interrupt_zero, irq;
  aiop_apin_type    analog_pin;
  aiop_tpin_type    timer_pin;
  aiop_tmr_out_type timer_out;
  aiop_tmr_in_type  timer_in;
  int               fails, checked, cyc;
  aiop_row_type     rows [4] = '{'{8'h00, 8'h00, 8'hff, 8'ha5, 8'h00},
    '{8'h00, 8'hff, 8'hff, 8'ha5, 8'ha5}, '{8'hff, 8'h00, 8'h3c, 8'h5a, 8'h3c},
    '{8'h0f, 8'hf0, 8'h96, 8'h33, 8'h36}};

  aiop_top uut (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .analog_pin_in(analog_pin_in),
    .analog_pin(analog_pin), .converter_upper_inputs(converter_upper_inputs),
    .timer_pin_in(timer_pin_in), .timer_pin(timer_pin),
    .timer_out(timer_out), .timer_in(timer_in),
    .external_interrupt_zero(external_interrupt_zero), .irq(irq));
  aiop_pin_model u_pins (.analog_pin(analog_pin), .timer_pin(timer_pin),
    .analog_ext(analog_ext), .timer_ext(timer_ext), .tmr_drive(tmr_drive),
    .analog_pin_in(analog_pin_in), .timer_pin_in(timer_pin_in),
    .timer_out(timer_out));

  // ----------------------------------------------------------
  // bus cycle, whole-register access only, held until answered
  // ----------------------------------------------------------
  task automatic xfer(input logic wr, input logic [5:0] idx,
                      input logic [7:0] wd, output logic [31:0] q);
    @(posedge core_clk);
    avs_address   <= {idx, 2'h0};
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_writedata <= {24'h0, wd};
    // only the bench timeout ends a wait that is never answered
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic complete_run;
    if (fails == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    rstn = 1'b0; avs_address = 8'h00; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = 32'h0; avs_byteenable = 4'hf; analog_ext = 8'h00;
    timer_ext = 6'h00; tmr_drive = 3'h0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    `CHK("a_lev", 8'hff, analog_pin.level);
    `CHK("a_oe", 8'h00, analog_pin.oe);
    `CHK("conv", 8'hff, converter_upper_inputs);
    `CHK("t_lev", 6'h3f, timer_pin.level);
    `CHK("t_oe", 6'h00, timer_pin.oe);
    analog_ext <= 8'h5a;
    timer_ext  <= 6'h2a;
    repeat (4) @(posedge core_clk);
    xfer(0, `AIOP_IDX_ANALOG_DATA, 8'h00, rd);
    `CHK("a_rd0", 32'h0, rd);
    xfer(0, `AIOP_IDX_TIMER_DATA, 8'h00, rd);
    `CHK("t_rd0", 32'h2a, rd);
    xfer(1, 6'h10, 8'hff, rd);
    xfer(0, 6'h10, 8'h00, rd);
    `CHK("unmapped", 32'h0, rd);
    foreach (rows[i]) begin
      xfer(1, `AIOP_IDX_ANALOG_DIR, rows[i].dir, rd);
      xfer(1, `AIOP_IDX_ANALOG_IE, rows[i].ie, rd);
      xfer(1, `AIOP_IDX_ANALOG_DATA, rows[i].latch, rd);
      analog_ext <= rows[i].ext;
      repeat (4) @(posedge core_clk);
      xfer(0, `AIOP_IDX_ANALOG_DATA, 8'h00, rd);
      `CHK("a_rd", {24'h0, rows[i].rd}, rd);
      `CHK("a_oe", rows[i].dir, analog_pin.oe);
      `CHK("conv", ~rows[i].dir, converter_upper_inputs);
      `CHK("a_lev", rows[i].latch, analog_pin.level);
    end
    // bit 5 kept as input so no reserved pairing is programmed
    xfer(1, `AIOP_IDX_TIMER_FSEL, 8'hff, rd);
    xfer(1, `AIOP_IDX_TIMER_DIR, 8'hdf, rd);
    xfer(1, `AIOP_IDX_TIMER_DATA, 8'h01, rd);
    for (int k = 0; k < 8; k++) begin
      tmr_drive <= k[2:0];
      repeat (3) @(posedge core_clk);
      `CHK("t_fn", {1'b0, k[0], 1'b0, k[1], k[2], 1'b1}, timer_pin.level);
    end
    `CHK("t_oe", 6'h1f, timer_pin.oe);
    repeat (4) @(posedge core_clk);
    `CHK("tin_out", 2'h2, timer_in);
    xfer(1, `AIOP_IDX_TIMER_DIR, 8'h00, rd);
    timer_ext <= 6'h08;
    repeat (6) @(posedge core_clk);
    `CHK("tin_in", 2'h1, timer_in);
    xfer(1, `AIOP_IDX_IRQ_MASK, 8'h01, rd);
    for (int m = 0; m < 4; m++) begin
      timer_ext <= {m[0], 5'h00};
      xfer(1, `AIOP_IDX_EXTERNAL_INTERRUPT_ZERO_MODE, m[7:0], rd);
      repeat (8) @(posedge core_clk);
      xfer(1, `AIOP_IDX_IRQ_STATUS, 8'h01, rd);
      repeat (4) @(posedge core_clk);
      `CHK("irq_idle", 1'b0, irq);
      timer_ext <= {~m[0], 5'h00};
      repeat (8) @(posedge core_clk);
      `CHK("irq_hit", 1'b1, irq);
      xfer(1, `AIOP_IDX_IRQ_STATUS, 8'h01, rd);
      repeat (4) @(posedge core_clk);
      `CHK("irq_clr", m[1], irq);
      `CHK("external_interrupt_zero_lvl", m[1], external_interrupt_zero);
    end
    xfer(1, `AIOP_IDX_EXTERNAL_INTERRUPT_ZERO_MODE, 8'h00, rd);
    xfer(1, `AIOP_IDX_IRQ_MASK, 8'h00, rd);
    xfer(1, `AIOP_IDX_IRQ_STATUS, 8'h01, rd);
    timer_ext <= 6'h20;
    repeat (8) @(posedge core_clk);
    `CHK("irq_mask", 1'b0, irq);
    xfer(0, `AIOP_IDX_IRQ_STATUS, 8'h00, rd);
    `CHK("status", 32'h1, rd);
    xfer(1, `AIOP_IDX_IRQ_MASK, 8'h01, rd);
    repeat (4) @(posedge core_clk);
    `CHK("irq_unmask", 1'b1, irq);
    // mid-run reset must undo written latches, directions, enables
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    `CHK("rst_apin", {8'hff, 8'h00}, analog_pin);
    `CHK("rst_tpin", {6'h3f, 6'h00}, timer_pin);
    xfer(0, `AIOP_IDX_ANALOG_DATA, 8'h00, rd);
    `CHK("rst_ard", 32'h0, rd);
    complete_run();
  end
endmodule // tb_top
